// ### src/atac_pkg.sv
// Package for the address table access block: byte map, field positions,
// reset values and operation codes shared by the design.
// Assumes a byte-wide management port with big-endian byte lanes per word.
package atac_pkg;
  // Byte addresses of the first byte of each 32-bit register, and of the last byte of entry word four
  localparam logic [15:0] ADDR_INDEX_ZERO = 16'h0410;
  localparam logic [15:0] ADDR_INDEX_ONE = 16'h0414;
  localparam logic [15:0] ADDR_DYN_CTRL = 16'h0418;
  localparam logic [15:0] ADDR_STAT_CTRL = 16'h041C;
  localparam logic [15:0] ADDR_ENTRY_ONE = 16'h0420;
  localparam logic [15:0] ADDR_ENTRY_TWO = 16'h0424;
  localparam logic [15:0] ADDR_ENTRY_THREE = 16'h0428;
  localparam logic [15:0] ADDR_ENTRY_FOUR = 16'h042C;
  localparam logic [15:0] ADDR_ENTRY_FOUR_LAST = 16'h042F;

  // Dynamic control fields
  localparam int DYN_START_BIT = 7;
  localparam int DYN_READY_BIT = 6;
  localparam int DYN_READY_OR_END_BIT = 5;
  localparam int DYN_DIRECT_BIT = 2;
  localparam int DYN_COUNT_LSB = 16;
  localparam logic [31:0] DYN_WR_MASK = 32'h0000009F;
  localparam logic [31:0] DYN_CTRL_RESET = 32'h00000000;

  // Static control fields
  localparam int STAT_START_BIT = 7;
  localparam int STAT_SELECT_BIT = 1;
  localparam int STAT_DIR_BIT = 0;
  localparam int STAT_INDEX_LSB = 16;
  localparam logic [31:0] STAT_WR_MASK = 32'h003F00FF;
  localparam logic [31:0] STAT_CTRL_RESET = 32'h00000000;

  // Index register fields
  localparam int GROUP_ID_LSB = 16;
  localparam logic [31:0] INDEX_ZERO_WR_MASK = 32'h807FFFFF;
  localparam logic [31:0] INDEX_RESET = 32'h00000000;
  localparam logic [31:0] ENTRY_RESET = 32'h00000000;

  // Entry word one bit that marks a dynamic entry as valid
  localparam int ENTRY_VALID_BIT = 31;

  // Table geometry
  localparam int DYN_DEPTH = 4096;
  localparam int DYN_AW = 12;
  localparam int STAT_DEPTH = 16;
  localparam int RSVD_DEPTH = 64;
  localparam int COUNT_W = 14;
  localparam logic [DYN_AW-1:0] DYN_LAST = 12'hFFF;

  // Dynamic table operations
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_SEARCH = 2'h3;

  // Search sequencer, Gray coded along idle, scan, wait
  typedef enum logic [1:0] {
    SRCH_IDLE = 2'b00,
    SRCH_SCAN = 2'b01,
    SRCH_WAIT = 2'b11
  } atac_srch_t;
endpackage

// ### src/atac_top.sv
// Indirect host access to the dynamic, static and reserved multicast tables.
// Assumes one clock, a byte-wide register port driven by the management
// front end, and single-cycle read/write strobes.
`timescale 1ns/10ps
`default_nettype none

module atac_top
  import atac_pkg::*;
(
  input wire logic CLOCK_IN, // System clock, 50 MHz
  input wire logic RST_IN, // Synchronous reset, active high
  input wire logic [15:0] REG_ADDR_IN, // Byte address
  input wire logic REG_WR_IN, // Byte write strobe
  input wire logic REG_RD_IN, // Byte read strobe
  input wire logic [7:0] REG_WDATA_IN, // Write byte
  output logic [7:0] REG_RDATA_OUT, // Read byte, registered
  output logic REG_RVALID_OUT, // Read byte valid, one cycle
  output logic BUSY_OUT // Any table operation in progress
);

  // Same 32-bit register, ignoring the byte lane
  function automatic logic reg_hit(input logic [15:0] a,
                                   input logic [15:0] base);
    reg_hit = (a[15:2] == base[15:2]);
  endfunction

  // Merge one big-endian byte lane into a word, writable bits only
  function automatic logic [31:0] put_byte(input logic [31:0] old,
                                           input logic [1:0] lane,
                                           input logic [7:0] d,
                                           input logic [31:0] mask);
    logic [31:0] w;
    w = old;
    case (lane)
      2'h0: w[31:24] = d;
      2'h1: w[23:16] = d;
      2'h2: w[15:8] = d;
      default: w[7:0] = d;
    endcase
    put_byte = (old & ~mask) | (w & mask);
  endfunction

  // Fold filter group id and address into a 12-bit table location
  function automatic logic [DYN_AW-1:0] hash_idx(input logic [6:0] grp,
                                                 input logic [47:0] mac);
    hash_idx = {5'h00, grp} ^ mac[11:0] ^ mac[23:12] ^ mac[35:24]
               ^ mac[47:36];
  endfunction

  // Tables; valid bits kept in flops so a search after reset sees none
  logic [127:0] dyn_mem [0:DYN_DEPTH-1];
  logic [127:0] stat_mem [0:STAT_DEPTH-1];
  logic [31:0] rsvd_mem [0:RSVD_DEPTH-1];
  logic [DYN_DEPTH-1:0] dyn_vld_ff, nxt_dyn_vld;

  logic [31:0] idx0_ff, nxt_idx0, idx1_ff, nxt_idx1;
  logic [31:0] dctl_ff, nxt_dctl, sctl_ff, nxt_sctl;
  logic [31:0] ent_ff [0:3];
  logic [31:0] nxt_ent [0:3];
  logic ready_ff, nxt_ready, srch_end_ff, nxt_srch_end;
  logic [COUNT_W-1:0] count_ff, nxt_count;
  logic [DYN_AW-1:0] ptr_ff, nxt_ptr;
  atac_srch_t state_ff, nxt_state;
  logic [7:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, busy_ff, nxt_busy;

  logic [1:0] lane;
  logic dyn_go, stat_go, last_rd;
  logic [DYN_AW-1:0] dyn_idx;
  logic [5:0] rsvd_idx;
  logic [3:0] stat_idx;
  logic dyn_we, stat_we, rsvd_we;
  logic [127:0] ent_all, dyn_rd, stat_rd;
  logic [31:0] dctl_view, rd_word;

  assign lane = REG_ADDR_IN[1:0];
  assign ent_all = {ent_ff[0], ent_ff[1], ent_ff[2], ent_ff[3]};
  assign dyn_go = dctl_ff[DYN_START_BIT] && (state_ff == SRCH_IDLE);
  assign stat_go = sctl_ff[STAT_START_BIT];
  assign last_rd = REG_RD_IN && (REG_ADDR_IN == ADDR_ENTRY_FOUR_LAST);
  // Direct location is only a debug aid; hashing is the normal path
  assign dyn_idx = dctl_ff[DYN_DIRECT_BIT] ? idx1_ff[11:0]
                 : hash_idx(idx0_ff[22:16], {idx0_ff[15:0], idx1_ff});
  assign rsvd_idx = sctl_ff[21:16];
  assign stat_idx = sctl_ff[19:16];
  assign dyn_rd = dyn_mem[dyn_go ? dyn_idx : ptr_ff];
  assign stat_rd = stat_mem[stat_idx];

  // Table write enables
  assign dyn_we = dyn_go && (dctl_ff[1:0] == OP_WRITE);
  assign stat_we = stat_go && !sctl_ff[STAT_SELECT_BIT]
                   && !sctl_ff[STAT_DIR_BIT];
  assign rsvd_we = stat_go && sctl_ff[STAT_SELECT_BIT]
                   && !sctl_ff[STAT_DIR_BIT];

  // Table storage, no reset on the data itself
  always_ff @(posedge CLOCK_IN) begin
    if (dyn_we) begin
      dyn_mem[dyn_idx] <= ent_all;
    end
    if (stat_we) begin
      stat_mem[stat_idx] <= ent_all;
    end
    if (rsvd_we) begin
      rsvd_mem[rsvd_idx] <= ent_ff[1];
    end
  end

  // Readable view of the dynamic control word; reserved bits stay zero
  always_comb begin
    dctl_view = dctl_ff & DYN_WR_MASK;
    dctl_view[DYN_READY_BIT] = ready_ff;
    dctl_view[DYN_READY_OR_END_BIT] = ready_ff || srch_end_ff;
    dctl_view[DYN_COUNT_LSB +: COUNT_W] = count_ff;
  end

  // Register writes, launches, table reads and the search walk
  always_comb begin
    nxt_idx0 = idx0_ff;
    nxt_idx1 = idx1_ff;
    nxt_dctl = dctl_ff;
    nxt_sctl = sctl_ff;
    nxt_ent = ent_ff;
    nxt_dyn_vld = dyn_vld_ff;
    nxt_ready = ready_ff;
    nxt_srch_end = srch_end_ff;
    nxt_count = count_ff;
    nxt_ptr = ptr_ff;
    nxt_state = state_ff;
    // Host writes; each control word drops writes while its own start bit is set
    if (REG_WR_IN) begin
      if (reg_hit(REG_ADDR_IN, ADDR_INDEX_ZERO))
        nxt_idx0 = put_byte(idx0_ff, lane, REG_WDATA_IN, INDEX_ZERO_WR_MASK);
      if (reg_hit(REG_ADDR_IN, ADDR_INDEX_ONE))
        nxt_idx1 = put_byte(idx1_ff, lane, REG_WDATA_IN, 32'hFFFFFFFF);
      if (reg_hit(REG_ADDR_IN, ADDR_DYN_CTRL) && !dctl_ff[DYN_START_BIT])
        nxt_dctl = put_byte(dctl_ff, lane, REG_WDATA_IN, DYN_WR_MASK);
      if (reg_hit(REG_ADDR_IN, ADDR_STAT_CTRL) && !sctl_ff[STAT_START_BIT])
        nxt_sctl = put_byte(sctl_ff, lane, REG_WDATA_IN, STAT_WR_MASK);
      for (int i = 0; i < 4; i++) begin
        if (reg_hit(REG_ADDR_IN, ADDR_ENTRY_ONE + 16'(4 * i)))
          nxt_ent[i] = put_byte(ent_ff[i], lane, REG_WDATA_IN, 32'hFFFFFFFF);
      end
    end
    // Static or multicast access, one cycle; device fill beats host write
    if (stat_go) begin
      if (sctl_ff[STAT_DIR_BIT]) begin
        if (sctl_ff[STAT_SELECT_BIT]) begin
          nxt_ent[1] = rsvd_mem[rsvd_idx];
        end else begin
          for (int i = 0; i < 4; i++)
            nxt_ent[i] = stat_rd[127 - 32 * i -: 32];
        end
      end
      nxt_sctl[STAT_START_BIT] = 1'b0;
    end
    case (state_ff)
      SRCH_IDLE: begin
        if (dyn_go) begin
          case (dctl_ff[1:0])
            OP_WRITE: begin
              nxt_dyn_vld[dyn_idx] = ent_ff[0][ENTRY_VALID_BIT];
              nxt_dctl[DYN_START_BIT] = 1'b0;
            end
            OP_READ: begin
              for (int i = 0; i < 4; i++)
                nxt_ent[i] = dyn_rd[127 - 32 * i -: 32];
              nxt_dctl[DYN_START_BIT] = 1'b0;
            end
            OP_SEARCH: begin
              nxt_state = SRCH_SCAN;
              nxt_ptr = '0;
              nxt_count = '0;
              nxt_srch_end = 1'b0;
            end
            default: nxt_dctl[DYN_START_BIT] = 1'b0;
          endcase
        end
      end
      SRCH_SCAN: begin
        // One location per cycle; a valid one parks the walk for the host
        if (dyn_vld_ff[ptr_ff]) begin
          for (int i = 0; i < 4; i++)
            nxt_ent[i] = dyn_rd[127 - 32 * i -: 32];
          nxt_ready = 1'b1;
          nxt_count = count_ff + 1'b1;
          nxt_state = SRCH_WAIT;
        end else if (ptr_ff == DYN_LAST) begin
          nxt_state = SRCH_IDLE;
          nxt_srch_end = 1'b1;
          nxt_dctl[DYN_START_BIT] = 1'b0;
        end else begin
          nxt_ptr = ptr_ff + 1'b1;
        end
      end
      SRCH_WAIT: begin
        // Host drains the entry ending at word four, then the walk resumes, or ends at the last location
        if (last_rd) begin
          nxt_ready = 1'b0;
          if (ptr_ff == DYN_LAST) begin
            nxt_state = SRCH_IDLE;
            nxt_srch_end = 1'b1;
            nxt_dctl[DYN_START_BIT] = 1'b0;
          end else begin
            nxt_ptr = ptr_ff + 1'b1;
            nxt_state = SRCH_SCAN;
          end
        end
      end
      default: nxt_state = SRCH_IDLE;
    endcase
    nxt_busy = nxt_dctl[DYN_START_BIT] || nxt_sctl[STAT_START_BIT];
  end

  // Read byte selection; unmapped addresses answer zero
  always_comb begin
    rd_word = 32'h00000000;
    if (reg_hit(REG_ADDR_IN, ADDR_INDEX_ZERO)) rd_word = idx0_ff;
    if (reg_hit(REG_ADDR_IN, ADDR_INDEX_ONE)) rd_word = idx1_ff;
    if (reg_hit(REG_ADDR_IN, ADDR_DYN_CTRL)) rd_word = dctl_view;
    if (reg_hit(REG_ADDR_IN, ADDR_STAT_CTRL)) rd_word = sctl_ff;
    for (int i = 0; i < 4; i++) begin
      if (reg_hit(REG_ADDR_IN, ADDR_ENTRY_ONE + 16'(4 * i)))
        rd_word = ent_ff[i];
    end
    nxt_rdata = REG_RD_IN ? rd_word[8 * (3 - lane) +: 8] : 8'h00;
  end

  // State registers
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      idx0_ff <= INDEX_RESET;
      idx1_ff <= INDEX_RESET;
      dctl_ff <= DYN_CTRL_RESET;
      sctl_ff <= STAT_CTRL_RESET;
      for (int i = 0; i < 4; i++) ent_ff[i] <= ENTRY_RESET;
      dyn_vld_ff <= '0;
      ready_ff <= 1'b0;
      srch_end_ff <= 1'b0;
      count_ff <= '0;
      ptr_ff <= '0;
      state_ff <= SRCH_IDLE;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      idx0_ff <= nxt_idx0;
      idx1_ff <= nxt_idx1;
      dctl_ff <= nxt_dctl;
      sctl_ff <= nxt_sctl;
      ent_ff <= nxt_ent;
      dyn_vld_ff <= nxt_dyn_vld;
      ready_ff <= nxt_ready;
      srch_end_ff <= nxt_srch_end;
      count_ff <= nxt_count;
      ptr_ff <= nxt_ptr;
      state_ff <= nxt_state;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= REG_RD_IN;
      busy_ff <= nxt_busy;
    end
  end

  assign REG_RDATA_OUT = rdata_ff;
  assign REG_RVALID_OUT = rvalid_ff;
  assign BUSY_OUT = busy_ff;

  // Checks
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);

  op_finish_a: assert property (dyn_go && dctl_ff[1:0] != OP_SEARCH
    |=> !dctl_ff[DYN_START_BIT])
    else $error("dynamic start bit not cleared after one-cycle op");
  ready_state_a: assert property (ready_ff |-> state_ff == SRCH_WAIT)
    else $error("entry ready outside the wait state");
  ready_clear_a: assert property (state_ff == SRCH_WAIT && last_rd
    |=> !ready_ff)
    else $error("entry ready not cleared by word four read");
  end_start_a: assert property ($rose(srch_end_ff)
    |-> $fell(dctl_ff[DYN_START_BIT]) && !ready_ff)
    else $error("search end without start bit clearing");
  count_step_a: assert property ($rose(ready_ff)
    |-> count_ff == $past(count_ff) + 1'b1)
    else $error("valid count not advanced on found entry");
  dyn_read_a: assert property (dyn_go && dctl_ff[1:0] == OP_READ
    |=> ent_ff[3] == $past(dyn_rd[31:0]))
    else $error("dynamic read did not fill entry word four");
  direct_wr_a: assert property (dyn_we && dctl_ff[DYN_DIRECT_BIT]
    |=> dyn_vld_ff[$past(idx1_ff[11:0])] == $past(ent_ff[0][31]))
    else $error("direct write landed at wrong location");
  rsvd_rd_a: assert property (stat_go && sctl_ff[1] && sctl_ff[0]
    |=> ent_ff[1] == $past(rsvd_mem[sctl_ff[21:16]])
        && ent_ff[0] == $past(ent_ff[0]))
    else $error("multicast read touched wrong entry word");
  stat_done_a: assert property (stat_go |=> !sctl_ff[STAT_START_BIT])
    else $error("static start bit not cleared");

  srch_done_c: cover property ($rose(srch_end_ff));
  entry_ready_c: cover property ($rose(ready_ff));
  rsvd_read_c: cover property (stat_go && sctl_ff[1] && sctl_ff[0]);
  stat_write_c: cover property (stat_we);

endmodule

`default_nettype wire

// ### testbench/atac_host.sv
// Host model: byte-wide register master for the table access block.
// Assumes read answers arrive one edge after the strobe edge.
`timescale 1ns/10ps
`default_nettype none
module atac_host (
  input wire logic clk_in, // System clock
  input wire logic [7:0] rdata_in, // Read byte
  input wire logic rvalid_in, // Read byte valid
  output logic [15:0] addr_out, // Byte address
  output logic wr_out, // Write strobe
  output logic rd_out, // Read strobe
  output logic [7:0] wdata_out // Write byte
);
  // Idle bus at time zero
  initial begin
    addr_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end

  // One strobe; released address and data lines invert so stale values never look valid
  task automatic put(input logic [15:0] a, input logic w,
                     input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wr_out <= w;
    rd_out <= ~w;
    wdata_out <= d;
    @(posedge clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask

  // Top byte first, so a start bit in byte three goes last
  task automatic wr_word(input logic [15:0] a, input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      put(a + 16'(i), 1'b1, v[31-8*i -: 8]);
    end
  endtask

  // Byte three last, so reading word four ends with its last byte
  task automatic rd_word(input logic [15:0] a, output logic [31:0] v,
                         output logic ok);
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      put(a + 16'(i), 1'b0, 8'h00);
      #1;
      ok = ok & (rvalid_in === 1'b1);
      v[31-8*i -: 8] = rdata_in;
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/address_table_access_control_test.sv
// Testbench for the table access block: scenario tasks over the byte port.
// Assumes atac_top and the host model; reads compare whole words.
`timescale 1ns/10ps
`default_nettype none
module address_table_access_control_test;
  import atac_pkg::*;
  localparam logic [127:0] E0 = 128'h00000055_0000000A_0000000B_0000000C;
  localparam logic [127:0] E1 = 128'h800000A1_11111111_22222222_33333333;
  localparam logic [127:0] E2 = 128'h800000B2_44444444_55555555_66666666;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] a;
  logic wr, rd, rv, busy;
  logic [7:0] wd, rdt;
  logic [31:0] c;
  logic [31:0] ke = 32'h0;
  int err_total = 0;
  int n_checks = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  atac_top dut (.CLOCK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(a),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wd),
    .REG_RDATA_OUT(rdt), .REG_RVALID_OUT(rv), .BUSY_OUT(busy));
  atac_host h (.clk_in(clk), .rdata_in(rdt), .rvalid_in(rv), .addr_out(a),
    .wr_out(wr), .rd_out(rd), .wdata_out(wd));

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask

  // Word read; a missing valid strobe turns the value unknown
  task automatic rc(input string s, input logic [15:0] ad,
                    input logic [31:0] e);
    logic ok;
    h.rd_word(ad, c, ok);
    chk(s, e, ok === 1'b1 ? c : 32'hX);
  endtask

  task automatic ents(input logic [127:0] e);
    for (int i = 0; i < 4; i++) begin
      h.wr_word(ADDR_ENTRY_ONE + 16'(4*i), e[127-32*i -: 32]);
    end
  endtask

  task automatic entc(input string s, input logic [127:0] e);
    for (int i = 0; i < 4; i++) begin
      rc(s, ADDR_ENTRY_ONE + 16'(4*i), e[127-32*i -: 32]);
    end
  endtask

  // Bounded wait for the busy level to drop
  task automatic idle();
    int n = 0;
    repeat (2) @(posedge clk);
    #1;
    while (busy !== 1'b0 && n < 9000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("busy", 32'h0, {31'h0, busy});
  endtask

  function automatic logic [11:0] hsh(input logic [6:0] f,
                                      input logic [47:0] m);
    return {5'h00, f} ^ m[11:0] ^ m[23:12] ^ m[35:24] ^ m[47:36];
  endfunction

  task automatic dgo(input logic [31:0] k);
    h.wr_word(ADDR_DYN_CTRL, k);
    idle();
    rc("dyn_ctrl", ADDR_DYN_CTRL, ke | (k & 32'h0000_001F));
  endtask

  task automatic sgo(input logic [31:0] k);
    h.wr_word(ADDR_STAT_CTRL, k);
    idle();
    rc("stat_ctrl", ADDR_STAT_CTRL, k & 32'h003F_007F);
  endtask

  // Poll until an entry is ready or the search is over
  task automatic poll();
    logic ok;
    int n = 0;
    do begin
      h.rd_word(ADDR_DYN_CTRL, c, ok);
      n++;
    end while (c[6] !== 1'b1 && c[7] !== 1'b0 && n < 1500);
  endtask

  task automatic s_rst();
    for (int i = 0; i < 8; i++) begin
      rc("reset", ADDR_INDEX_ZERO + 16'(4*i), 32'h0);
    end
    rc("unmapped", 16'h0500, 32'h0);
    h.wr_word(ADDR_DYN_CTRL, 32'hFFFF_FF7F);
    rc("dyn_ro", ADDR_DYN_CTRL, 32'h0000_001F);
    h.wr_word(ADDR_DYN_CTRL, 32'h0);
    h.wr_word(ADDR_STAT_CTRL, 32'hFFFF_FF7F);
    rc("stat_ro", ADDR_STAT_CTRL, 32'h003F_007F);
    h.wr_word(ADDR_STAT_CTRL, 32'h0);
    h.wr_word(ADDR_INDEX_ZERO, 32'hFFFF_FFFF);
    rc("idx0_ro", ADDR_INDEX_ZERO, 32'h807F_FFFF);
  endtask

  // Direct write and read at the last location, noop, invalid entry
  task automatic s_dyn();
    h.wr_word(ADDR_INDEX_ONE, 32'h0000_0FFF);
    ents(E1);
    dgo(32'h0000_0085);
    ents('0);
    dgo(32'h0000_0086);
    entc("dyn_rd", E1);
    h.wr_word(ADDR_ENTRY_ONE, 32'h0000_0011);
    dgo(32'h0000_0084);
    rc("noop", ADDR_ENTRY_ONE, 32'h0000_0011);
    h.wr_word(ADDR_INDEX_ONE, 32'h0);
    ents(E0);
    dgo(32'h0000_0085);
  endtask

  // Hashed write, read back directly at the computed location
  task automatic s_hash();
    h.wr_word(ADDR_INDEX_ZERO, 32'h0005_0000);
    h.wr_word(ADDR_INDEX_ONE, 32'h0000_0123);
    ents(E2);
    dgo(32'h0000_0081);
    h.wr_word(ADDR_INDEX_ONE, {20'h00000, hsh(7'h05, 48'h123)});
    ents('0);
    dgo(32'h0000_0086);
    entc("hash_rd", E2);
  endtask

  // Two valid entries found in order, one invalid skipped
  task automatic s_srch();
    logic [127:0] ex [2];
    ex[0] = E2;
    ex[1] = E1;
    h.wr_word(ADDR_DYN_CTRL, 32'h0000_0083);
    for (int k = 0; k < 2; k++) begin
      poll();
      chk("ready", 32'h0000_0060, c & 32'h0000_0060);
      entc("found", ex[k]);
      if (k == 0) begin
        rc("rdy_clr", ADDR_DYN_CTRL, 32'h0001_0083);
      end
    end
    poll();
    chk("srch_end", 32'h0002_0023, c);
    ke = 32'h0002_0020;
  endtask

  // Static index uses four bits, multicast six bits and word two only
  task automatic s_stat();
    ents(E1);
    sgo(32'h003F_0080);
    ents('0);
    sgo(32'h000F_0081);
    entc("stat_rd", E1);
    h.wr_word(ADDR_ENTRY_TWO, 32'hA5A5_0001);
    sgo(32'h002A_0082);
    h.wr_word(ADDR_ENTRY_TWO, 32'h0000_0B0B);
    sgo(32'h000A_0082);
    h.wr_word(ADDR_ENTRY_ONE, 32'h1234_5678);
    sgo(32'h002A_0083);
    rc("mc_rd", ADDR_ENTRY_TWO, 32'hA5A5_0001);
    rc("mc_w1", ADDR_ENTRY_ONE, 32'h1234_5678);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    s_rst();
    s_dyn();
    s_hash();
    s_srch();
    s_stat();
    wrap_up();
  end

  // Watchdog, well past the search and register traffic
  initial begin
    #1000000;
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
